// ===== dacr_pkg.sv
// Package with register map, field positions and reset values of the configuration bank.
package dacr_pkg;

    localparam int ADDR_W = 10;
    localparam int DATA_W = 8;

    localparam logic [9:0] OFS_POWER_MODES   = 10'h008;
    localparam logic [9:0] OFS_REF_SELECT    = 10'h018;
    localparam logic [9:0] OFS_PAT_ONE_LOW   = 10'h019;
    localparam logic [9:0] OFS_PAT_ONE_HIGH  = 10'h01a;
    localparam logic [9:0] OFS_PAT_TWO_LOW   = 10'h01b;
    localparam logic [9:0] OFS_PAT_TWO_HIGH  = 10'h01c;
    localparam logic [9:0] OFS_OVERRANGE     = 10'h02a;
    localparam logic [9:0] OFS_OUT_ASSIGN    = 10'h02e;
    localparam logic [9:0] OFS_SYNC_CONTROL  = 10'h03a;
    localparam logic [9:0] OFS_TRANSFER      = 10'h0ff;
    localparam logic [9:0] OFS_RATE_OVERRIDE = 10'h100;
    localparam logic [9:0] OFS_PIN_CTRL_TWO  = 10'h101;
    localparam logic [9:0] OFS_PIN_CTRL_THREE = 10'h102;

    localparam logic [7:0] RST_ZERO          = 8'h00;
    localparam logic [7:0] RST_OVERRANGE     = 8'h01;
    localparam logic [7:0] RST_ASSIGN_A      = 8'h00;
    localparam logic [7:0] RST_ASSIGN_B      = 8'h01;
    localparam logic [7:0] RST_PIN_CTRL_TWO  = 8'h80;

    localparam int BIT_PIN_FULL_PD   = 5;
    localparam int BIT_TRANSFER      = 0;
    localparam int BIT_OVR_ENABLE    = 0;
    localparam int BIT_ASSIGN        = 0;
    localparam int BIT_SYNC_ENABLE   = 1;
    localparam int BIT_SYNC_NEXT     = 2;
    localparam int BIT_RATE_OVR_EN   = 6;
    localparam int BIT_OE_PIN_EN     = 7;
    localparam int BIT_SDIO_PD_DIS   = 0;
    localparam int BIT_CM_PWDN       = 3;

    // Field positions of the power-mode field and of the override codes.
    localparam int FLD_MODE_HI = 1;
    localparam int FLD_MODE_LO = 0;
    localparam int FLD_RES_HI  = 5;
    localparam int FLD_RES_LO  = 3;
    localparam int FLD_RATE_HI = 2;
    localparam int FLD_RATE_LO = 0;

    localparam logic [1:0] MODE_NORMAL  = 2'h0;
    localparam logic [1:0] MODE_PWRDOWN = 2'h1;
    localparam logic [1:0] MODE_STANDBY = 2'h2;
    localparam logic [1:0] MODE_DRESET  = 2'h3;

    localparam logic [2:0] RES_12BIT = 3'h4;
    localparam logic [2:0] RES_10BIT = 3'h6;
    localparam logic [2:0] RATE_80   = 3'h3;
    localparam logic [2:0] RATE_105  = 3'h4;
    localparam logic [2:0] RATE_125  = 3'h5;

    // Register write request from the serial port decoder.
    typedef struct packed {
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } dacr_req_t;

    // Data path controls derived from the power mode.
    typedef struct packed {
        logic clk_stop;
        logic path_reset;
        logic out_disable;
        logic full_pd;
    } dacr_pwr_t;

endpackage

// ===== dacr_regs.sv
// Upper configuration register bank of the dual converter with power and sync control.
`timescale 1ns/100ps
module dacr_regs
    import dacr_pkg::*;
(
    // Clock and reset.
    input  wire logic              SYS_CLK,
    input  wire logic              RESET,
    // Register access from the serial control port.
    input  wire dacr_req_t         REQ,
    input  wire logic              CHAN_SEL_A,
    input  wire logic              CHAN_SEL_B,
    output logic [DATA_W-1:0]      RDATA,
    // Device pins.
    input  wire logic              POWER_DOWN_PIN,
    input  wire logic              SYNC_PULSE,
    // Power and data path control.
    output dacr_pwr_t              PWR_CTRL,
    output logic                   BOTH_CHANNELS_ACTIVE,
    // Channel configuration.
    output logic                   OVERRANGE_OUT_EN,
    output logic                   ASSIGN_A,
    output logic                   ASSIGN_B,
    output logic [DATA_W-1:0]      REF_SELECT,
    output logic [15:0]            PATTERN_ONE,
    output logic [15:0]            PATTERN_TWO,
    // Clock divider sync.
    output logic                   DIVIDER_REALIGN,
    // Applied rate and resolution override.
    output logic                   RATE_OVR_ACTIVE,
    output logic [2:0]             RATE_CODE,
    output logic [2:0]             RES_CODE,
    output logic                   RES_IS_12BIT,
    output logic                   RES_IS_10BIT,
    output logic                   RATE_IS_80,
    output logic                   RATE_IS_105,
    output logic                   RATE_IS_125,
    // Pin controls.
    output logic                   OE_PIN_ENABLE,
    output logic                   SDIO_PULLDOWN_OFF,
    output logic                   COMMON_MODE_GENERATOR_PD
);

    ////////////////////////////////////////////////////////////////////////////
    // Register state.

    logic [7:0] power_modes_reg,   power_modes_next;
    logic [7:0] ref_select_reg,    ref_select_next;
    logic [7:0] pat_one_lo_reg,    pat_one_lo_next;
    logic [7:0] pat_one_hi_reg,    pat_one_hi_next;
    logic [7:0] pat_two_lo_reg,    pat_two_lo_next;
    logic [7:0] pat_two_hi_reg,    pat_two_hi_next;
    logic [7:0] overrange_reg,     overrange_next;
    logic [7:0] assign_a_reg,      assign_a_next;
    logic [7:0] assign_b_reg,      assign_b_next;
    logic [7:0] sync_ctrl_reg,     sync_ctrl_next;
    logic [7:0] rate_shadow_reg,   rate_shadow_next;
    logic [7:0] rate_live_reg,     rate_live_next;
    logic [7:0] pin_two_reg,       pin_two_next;
    logic [7:0] pin_three_reg,     pin_three_next;
    logic       realign_reg,       realign_next;
    logic [7:0] rdata_reg,         rdata_next;

    function automatic logic hit(input logic [ADDR_W-1:0] ofs);
        hit = REQ.wr && (REQ.addr == ofs);
    endfunction

    always_comb begin
        power_modes_next = hit(OFS_POWER_MODES)  ? REQ.wdata : power_modes_reg;
        ref_select_next  = hit(OFS_REF_SELECT)   ? REQ.wdata : ref_select_reg;
        pat_one_lo_next  = hit(OFS_PAT_ONE_LOW)  ? REQ.wdata : pat_one_lo_reg;
        pat_one_hi_next  = hit(OFS_PAT_ONE_HIGH) ? REQ.wdata : pat_one_hi_reg;
        pat_two_lo_next  = hit(OFS_PAT_TWO_LOW)  ? REQ.wdata : pat_two_lo_reg;
        pat_two_hi_next  = hit(OFS_PAT_TWO_HIGH) ? REQ.wdata : pat_two_hi_reg;
        overrange_next   = hit(OFS_OVERRANGE)    ? REQ.wdata : overrange_reg;
        pin_two_next     = hit(OFS_PIN_CTRL_TWO) ? REQ.wdata : pin_two_reg;
        pin_three_next   = hit(OFS_PIN_CTRL_THREE) ? REQ.wdata : pin_three_reg;
        // Output assign is local: only the channels selected by the index take the write.
        assign_a_next = (hit(OFS_OUT_ASSIGN) && CHAN_SEL_A) ? REQ.wdata : assign_a_reg;
        assign_b_next = (hit(OFS_OUT_ASSIGN) && CHAN_SEL_B) ? REQ.wdata : assign_b_reg;
        // The override is staged and applied only by the transfer bit.
        rate_shadow_next = hit(OFS_RATE_OVERRIDE) ? REQ.wdata : rate_shadow_reg;
        rate_live_next   = rate_live_reg;
        if (hit(OFS_TRANSFER) && REQ.wdata[BIT_TRANSFER]) begin
            rate_live_next = rate_shadow_reg;
        end
        // Sync: a pulse realigns while enabled; next-sync-only drops the enable afterwards.
        realign_next   = SYNC_PULSE && sync_ctrl_reg[BIT_SYNC_ENABLE];
        sync_ctrl_next = hit(OFS_SYNC_CONTROL) ? REQ.wdata : sync_ctrl_reg;
        if (realign_next && sync_ctrl_reg[BIT_SYNC_NEXT]) begin
            sync_ctrl_next[BIT_SYNC_ENABLE] = 1'b0;
        end
        case (REQ.addr)
            OFS_POWER_MODES:    rdata_next = power_modes_reg;
            OFS_REF_SELECT:     rdata_next = ref_select_reg;
            OFS_PAT_ONE_LOW:    rdata_next = pat_one_lo_reg;
            OFS_PAT_ONE_HIGH:   rdata_next = pat_one_hi_reg;
            OFS_PAT_TWO_LOW:    rdata_next = pat_two_lo_reg;
            OFS_PAT_TWO_HIGH:   rdata_next = pat_two_hi_reg;
            OFS_OVERRANGE:      rdata_next = overrange_reg;
            OFS_OUT_ASSIGN:     rdata_next = CHAN_SEL_A ? assign_a_reg : assign_b_reg;
            OFS_SYNC_CONTROL:   rdata_next = sync_ctrl_reg;
            OFS_RATE_OVERRIDE:  rdata_next = rate_shadow_reg;
            OFS_PIN_CTRL_TWO:   rdata_next = pin_two_reg;
            OFS_PIN_CTRL_THREE: rdata_next = pin_three_reg;
            default:            rdata_next = RST_ZERO;
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            power_modes_reg <= RST_ZERO;
            ref_select_reg  <= RST_ZERO;
            pat_one_lo_reg  <= RST_ZERO;
            pat_one_hi_reg  <= RST_ZERO;
            pat_two_lo_reg  <= RST_ZERO;
            pat_two_hi_reg  <= RST_ZERO;
            overrange_reg   <= RST_OVERRANGE;
            assign_a_reg    <= RST_ASSIGN_A;
            assign_b_reg    <= RST_ASSIGN_B;
            sync_ctrl_reg   <= RST_ZERO;
            rate_shadow_reg <= RST_ZERO;
            rate_live_reg   <= RST_ZERO;
            pin_two_reg     <= RST_PIN_CTRL_TWO;
            pin_three_reg   <= RST_ZERO;
            realign_reg     <= 1'b0;
            rdata_reg       <= RST_ZERO;
        end else begin
            power_modes_reg <= power_modes_next;
            ref_select_reg  <= ref_select_next;
            pat_one_lo_reg  <= pat_one_lo_next;
            pat_one_hi_reg  <= pat_one_hi_next;
            pat_two_lo_reg  <= pat_two_lo_next;
            pat_two_hi_reg  <= pat_two_hi_next;
            overrange_reg   <= overrange_next;
            assign_a_reg    <= assign_a_next;
            assign_b_reg    <= assign_b_next;
            sync_ctrl_reg   <= sync_ctrl_next;
            rate_shadow_reg <= rate_shadow_next;
            rate_live_reg   <= rate_live_next;
            pin_two_reg     <= pin_two_next;
            pin_three_reg   <= pin_three_next;
            realign_reg     <= realign_next;
            rdata_reg       <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Power mode decode. The pin overrides the register mode while asserted.

    logic [1:0] mode_field;

    assign mode_field = power_modes_reg[FLD_MODE_HI:FLD_MODE_LO];

    dacr_pwr_t pwr_reg, pwr_next;

    always_comb begin
        pwr_next = '0;
        if (POWER_DOWN_PIN) begin
            pwr_next.clk_stop    = 1'b1;
            pwr_next.out_disable = 1'b1;
            pwr_next.full_pd     = power_modes_reg[BIT_PIN_FULL_PD];
            pwr_next.path_reset  = power_modes_reg[BIT_PIN_FULL_PD];
        end else begin
            case (mode_field)
                MODE_NORMAL: pwr_next = '0;
                MODE_PWRDOWN: begin
                    pwr_next.clk_stop    = 1'b1;
                    pwr_next.path_reset  = 1'b1;
                    pwr_next.out_disable = 1'b1;
                    pwr_next.full_pd     = 1'b1;
                end
                MODE_STANDBY: begin
                    pwr_next.clk_stop    = 1'b1;
                    pwr_next.out_disable = 1'b1;
                end
                MODE_DRESET: begin
                    pwr_next.clk_stop    = 1'b1;
                    pwr_next.path_reset  = 1'b1;
                end
                default: pwr_next = '0;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            pwr_reg <= '0;
        end else begin
            pwr_reg <= pwr_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign RDATA                    = rdata_reg;
    assign PWR_CTRL                 = pwr_reg;
    assign BOTH_CHANNELS_ACTIVE     = ~pwr_reg.clk_stop;
    assign OVERRANGE_OUT_EN         = overrange_reg[BIT_OVR_ENABLE];
    assign ASSIGN_A                 = assign_a_reg[BIT_ASSIGN];
    assign ASSIGN_B                 = assign_b_reg[BIT_ASSIGN];
    assign REF_SELECT               = ref_select_reg;
    assign PATTERN_ONE              = {pat_one_hi_reg, pat_one_lo_reg};
    assign PATTERN_TWO              = {pat_two_hi_reg, pat_two_lo_reg};
    assign DIVIDER_REALIGN          = realign_reg;
    assign RATE_OVR_ACTIVE          = rate_live_reg[BIT_RATE_OVR_EN];
    assign RES_CODE                 = rate_live_reg[FLD_RES_HI:FLD_RES_LO];
    assign RATE_CODE                = rate_live_reg[FLD_RATE_HI:FLD_RATE_LO];
    assign RES_IS_12BIT             = RATE_OVR_ACTIVE && (RES_CODE == RES_12BIT);
    assign RES_IS_10BIT             = RATE_OVR_ACTIVE && (RES_CODE == RES_10BIT);
    assign RATE_IS_80               = RATE_OVR_ACTIVE && (RATE_CODE == RATE_80);
    assign RATE_IS_105              = RATE_OVR_ACTIVE && (RATE_CODE == RATE_105);
    assign RATE_IS_125              = RATE_OVR_ACTIVE && (RATE_CODE == RATE_125);
    assign OE_PIN_ENABLE            = pin_two_reg[BIT_OE_PIN_EN];
    assign SDIO_PULLDOWN_OFF        = pin_two_reg[BIT_SDIO_PD_DIS];
    assign COMMON_MODE_GENERATOR_PD = pin_three_reg[BIT_CM_PWDN];

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    property p_pin_mode;
        @(posedge SYS_CLK) disable iff (RESET)
        POWER_DOWN_PIN |=> PWR_CTRL.clk_stop && PWR_CTRL.out_disable
            && (PWR_CTRL.full_pd == $past(power_modes_reg[BIT_PIN_FULL_PD]));
    endproperty
    a_pin_mode: assert property (p_pin_mode) else $error("pin power-down wrong");

    property p_standby;
        @(posedge SYS_CLK) disable iff (RESET)
        (!POWER_DOWN_PIN && mode_field == MODE_STANDBY)
            |=> PWR_CTRL.clk_stop && PWR_CTRL.out_disable && !PWR_CTRL.path_reset;
    endproperty
    a_standby: assert property (p_standby) else $error("standby controls wrong");

    property p_dreset;
        @(posedge SYS_CLK) disable iff (RESET)
        (!POWER_DOWN_PIN && mode_field == MODE_DRESET)
            |=> PWR_CTRL.path_reset && !PWR_CTRL.out_disable;
    endproperty
    a_dreset: assert property (p_dreset) else $error("digital reset controls wrong");

    property p_normal;
        @(posedge SYS_CLK) disable iff (RESET)
        (!POWER_DOWN_PIN && mode_field == MODE_NORMAL) |=> BOTH_CHANNELS_ACTIVE;
    endproperty
    a_normal: assert property (p_normal) else $error("normal mode not active");

    property p_transfer;
        @(posedge SYS_CLK) disable iff (RESET)
        !(REQ.wr && REQ.addr == OFS_TRANSFER) |=> $stable(rate_live_reg);
    endproperty
    a_transfer: assert property (p_transfer) else $error("override applied early");

    property p_sync_once;
        @(posedge SYS_CLK) disable iff (RESET)
        (SYNC_PULSE && sync_ctrl_reg[BIT_SYNC_ENABLE] && sync_ctrl_reg[BIT_SYNC_NEXT]
            && !REQ.wr) |=> DIVIDER_REALIGN && !sync_ctrl_reg[BIT_SYNC_ENABLE];
    endproperty
    a_sync_once: assert property (p_sync_once) else $error("one-shot sync failed");

    property p_sync_gate;
        @(posedge SYS_CLK) disable iff (RESET)
        DIVIDER_REALIGN |-> $past(SYNC_PULSE && sync_ctrl_reg[BIT_SYNC_ENABLE]);
    endproperty
    a_sync_gate: assert property (p_sync_gate) else $error("realign without pulse");

    property p_immediate;
        @(posedge SYS_CLK) disable iff (RESET)
        (REQ.wr && REQ.addr == OFS_OVERRANGE)
            |=> OVERRANGE_OUT_EN == $past(REQ.wdata[BIT_OVR_ENABLE]);
    endproperty
    a_immediate: assert property (p_immediate) else $error("overrange not updated");

    property p_pwrdown;
        @(posedge SYS_CLK) disable iff (RESET)
        (!POWER_DOWN_PIN && mode_field == MODE_PWRDOWN)
            |=> PWR_CTRL.clk_stop && PWR_CTRL.path_reset && PWR_CTRL.out_disable;
    endproperty
    a_pwrdown: assert property (p_pwrdown) else $error("power-down controls wrong");

    property p_cm_pd;
        @(posedge SYS_CLK) disable iff (RESET)
        (REQ.wr && REQ.addr == OFS_PIN_CTRL_THREE)
            |=> COMMON_MODE_GENERATOR_PD == $past(REQ.wdata[BIT_CM_PWDN]);
    endproperty
    a_cm_pd: assert property (p_cm_pd) else $error("generator power-down not updated");

    property p_assign_a;
        @(posedge SYS_CLK) disable iff (RESET)
        (REQ.wr && REQ.addr == OFS_OUT_ASSIGN && CHAN_SEL_A)
            |=> ASSIGN_A == $past(REQ.wdata[BIT_ASSIGN]);
    endproperty
    a_assign_a: assert property (p_assign_a) else $error("channel A assign not updated");

endmodule

// ===== dacr_host.sv
// Host model that drives register writes and reads on the control port.
`timescale 1ns/100ps
module dacr_host
    import dacr_pkg::*;
(
    // Clock.
    input  wire logic         SYS_CLK,
    // Control port.
    output dacr_req_t         REQ,
    output logic              CHAN_SEL_A,
    output logic              CHAN_SEL_B,
    input  wire logic [7:0]   RDATA
);
    initial begin
        REQ = '0;
        CHAN_SEL_A = 1'b1;
        CHAN_SEL_B = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Entered just after a falling edge; the request stands over one rising edge.
    task automatic write_reg(input logic [9:0] a, input logic [7:0] d);
        REQ = '{wr: 1'b1, addr: a, wdata: d};
        @(negedge SYS_CLK);
    endtask
    // Released write data is inverted so a stale byte never looks valid.
    task automatic idle();
        REQ.wr = 1'b0;
        REQ.wdata = ~REQ.wdata;
    endtask
    task automatic read_reg(input logic [9:0] a, output logic [7:0] d);
        REQ = '{wr: 1'b0, addr: a, wdata: ~REQ.wdata};
        @(negedge SYS_CLK);
        d = RDATA;
    endtask
    task automatic select(input logic a, input logic b);
        CHAN_SEL_A = a;
        CHAN_SEL_B = b;
    endtask
    // Both channels are picked before a mode write, though the power modes register takes the write whatever the selection.
    task automatic set_mode(input logic [7:0] d);
        select(1'b1, 1'b1);
        write_reg(OFS_POWER_MODES, d);
        idle();
    endtask
endmodule

// ===== tb_top.sv
// Self-checking testbench of the upper configuration register bank.
`timescale 1ns/100ps
module tb_top;
    import dacr_pkg::*;
    logic        sys_clk, reset, pd_pin, sync_pulse, chan_a, chan_b, both_act, ovr_en;
    logic        asg_a, asg_b, realign, r_act, res12, res10, r80, r105, r125, oe_en, sdio_off;
    logic        cm_pd;
    logic [7:0]  rdata, ref_sel;
    logic [15:0] pat_one, pat_two;
    logic [2:0]  rate_code, res_code;
    dacr_req_t   req;
    dacr_pwr_t   pwr;
    int          err_count, total_checks;
    dacr_host dacr_host_i (.SYS_CLK(sys_clk), .REQ(req), .CHAN_SEL_A(chan_a),
        .CHAN_SEL_B(chan_b), .RDATA(rdata));
    dacr_regs dacr_regs_i (.SYS_CLK(sys_clk), .RESET(reset), .REQ(req), .CHAN_SEL_A(chan_a),
        .CHAN_SEL_B(chan_b), .RDATA(rdata), .POWER_DOWN_PIN(pd_pin), .SYNC_PULSE(sync_pulse),
        .PWR_CTRL(pwr), .BOTH_CHANNELS_ACTIVE(both_act), .OVERRANGE_OUT_EN(ovr_en),
        .ASSIGN_A(asg_a), .ASSIGN_B(asg_b), .REF_SELECT(ref_sel), .PATTERN_ONE(pat_one),
        .PATTERN_TWO(pat_two), .DIVIDER_REALIGN(realign), .RATE_OVR_ACTIVE(r_act),
        .RATE_CODE(rate_code), .RES_CODE(res_code), .RES_IS_12BIT(res12), .RES_IS_10BIT(res10),
        .RATE_IS_80(r80), .RATE_IS_105(r105), .RATE_IS_125(r125), .OE_PIN_ENABLE(oe_en),
        .SDIO_PULLDOWN_OFF(sdio_off), .COMMON_MODE_GENERATOR_PD(cm_pd));
    initial sys_clk = 1'b0;
    always #2.5 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd(input logic [9:0] a, input logic [7:0] exp);
        logic [7:0] d;
        dacr_host_i.read_reg(a, d);
        check(16'(d), 16'(exp));
    endtask
    task automatic final_report();
        if (err_count == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd(OFS_OVERRANGE, 8'h01);
        dacr_host_i.select(1'b1, 1'b0);
        rd(OFS_OUT_ASSIGN, 8'h00);
        dacr_host_i.select(1'b0, 1'b1);
        rd(OFS_OUT_ASSIGN, 8'h01);
        rd(OFS_PIN_CTRL_TWO, 8'h80);
        rd(OFS_PIN_CTRL_THREE, 8'h00);
        rd(OFS_SYNC_CONTROL, 8'h00);
        rd(OFS_RATE_OVERRIDE, 8'h00);
        for (int i = 0; i < 4; i++) rd(10'(OFS_PAT_ONE_LOW + i), 8'h00);
        rd(10'h3ff, 8'h00);
        check(16'({ovr_en, asg_a, asg_b}), 16'h5);
        check(16'({oe_en, sdio_off, cm_pd, both_act}), 16'h9);
    endtask
    task automatic t_power();
        logic [3:0] exp_pwr [4] = '{4'h0, 4'hf, 4'ha, 4'hc};
        for (int m = 0; m < 4; m++) begin
            dacr_host_i.set_mode(8'(m));
            repeat (2) @(negedge sys_clk);
            check(16'(pwr), 16'(exp_pwr[m]));
            check(16'(both_act), 16'(m == 0));
        end
        dacr_host_i.set_mode(8'h20);
        pd_pin = 1'b1;
        repeat (2) @(negedge sys_clk);
        check(16'(pwr), 16'h000f);
        rd(OFS_POWER_MODES, 8'h20);
        dacr_host_i.set_mode(8'h00);
        repeat (2) @(negedge sys_clk);
        check(16'(pwr), 16'h000a);
        pd_pin = 1'b0;
        repeat (2) @(negedge sys_clk);
        check(16'(pwr), 16'h0000);
    endtask
    task automatic t_cfg();
        dacr_host_i.select(1'b1, 1'b1);
        dacr_host_i.write_reg(OFS_PAT_ONE_LOW, 8'h34);
        dacr_host_i.write_reg(OFS_PAT_ONE_HIGH, 8'h12);
        dacr_host_i.write_reg(OFS_PAT_TWO_LOW, 8'h78);
        dacr_host_i.write_reg(OFS_PAT_TWO_HIGH, 8'h56);
        dacr_host_i.write_reg(OFS_OVERRANGE, 8'h00);
        dacr_host_i.write_reg(OFS_OUT_ASSIGN, 8'h01);
        dacr_host_i.write_reg(OFS_REF_SELECT, 8'h5a);
        dacr_host_i.write_reg(OFS_PIN_CTRL_TWO, 8'h01);
        dacr_host_i.write_reg(OFS_PIN_CTRL_THREE, 8'h08);
        dacr_host_i.write_reg(10'h3ff, 8'hff);
        dacr_host_i.idle();
        @(negedge sys_clk);
        check(pat_one, 16'h1234);
        check(pat_two, 16'h5678);
        check(16'(ref_sel), 16'h005a);
        check(16'({ovr_en, asg_a, asg_b, oe_en, sdio_off, cm_pd}), 16'h1b);
        rd(10'h3ff, 8'h00);
        rd(OFS_PIN_CTRL_TWO, 8'h01);
        rd(OFS_REF_SELECT, 8'h5a);
        dacr_host_i.select(1'b1, 1'b0);
        dacr_host_i.write_reg(OFS_OUT_ASSIGN, 8'h00);
        dacr_host_i.idle();
        @(negedge sys_clk);
        check(16'({asg_a, asg_b}), 16'h1);
    endtask
    task automatic t_override();
        logic [7:0] val [4] = '{8'h64, 8'h75, 8'h5b, 8'h24};
        logic [5:0] dec [4] = '{6'h32, 6'h29, 6'h24, 6'h00};
        logic [5:0] prev = 6'h00;
        for (int i = 0; i < 4; i++) begin
            dacr_host_i.write_reg(OFS_RATE_OVERRIDE, val[i]);
            dacr_host_i.write_reg(OFS_TRANSFER, 8'h02);
            rd(OFS_RATE_OVERRIDE, val[i]);
            check(16'({r_act, res12, res10, r80, r105, r125}), 16'(prev));
            dacr_host_i.write_reg(OFS_TRANSFER, 8'h01);
            dacr_host_i.idle();
            repeat (2) @(negedge sys_clk);
            check(16'({r_act, res12, res10, r80, r105, r125}), 16'(dec[i]));
            check(16'({res_code, rate_code}), 16'(val[i][5:0]));
            prev = dec[i];
        end
        rd(OFS_TRANSFER, 8'h00);
    endtask
    task automatic pulse(input logic exp);
        sync_pulse = 1'b1;
        @(negedge sys_clk);
        sync_pulse = 1'b0;
        check(16'(realign), 16'(exp));
        @(negedge sys_clk);
        check(16'(realign), 16'h0000);
    endtask
    task automatic t_sync();
        pulse(1'b0);
        dacr_host_i.write_reg(OFS_SYNC_CONTROL, 8'h02);
        dacr_host_i.idle();
        pulse(1'b1);
        pulse(1'b1);
        rd(OFS_SYNC_CONTROL, 8'h02);
        dacr_host_i.write_reg(OFS_SYNC_CONTROL, 8'h06);
        dacr_host_i.idle();
        pulse(1'b1);
        rd(OFS_SYNC_CONTROL, 8'h04);
        pulse(1'b0);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        err_count = 0;
        total_checks = 0;
        reset = 1'b1;
        pd_pin = 1'b0;
        sync_pulse = 1'b0;
        repeat (4) @(negedge sys_clk);
        reset = 1'b0;
        t_reset();
        t_power();
        t_cfg();
        t_override();
        t_sync();
        final_report();
    end
    // The whole sequence needs about a hundred cycles; this allows many times that.
    initial begin
        #100000;
        err_count++;
        final_report();
    end
endmodule
